/* File: shared/fpg_pkg.sv */
// Package: constants and types of the flash protection gate
package fpg_pkg;
	localparam int FPG_ADDR_W = 4;
	localparam int FPG_DATA_W = 32;
	localparam int FPG_NFLAG = 5;
	// Flag bit positions
	localparam int FPG_F_BLKERA = 0;
	localparam int FPG_F_CHPERA = 1;
	localparam int FPG_F_PROG = 2;
	localparam int FPG_F_READ = 3;
	localparam int FPG_F_BOOT = 4;
	localparam logic [FPG_NFLAG-1:0] FPG_FLAGS_RST = 5'h00;
	// Register byte offsets
	localparam logic [FPG_ADDR_W-1:0] FPG_OFF_FLAGS = 4'h0;
	localparam logic [FPG_ADDR_W-1:0] FPG_OFF_STATUS = 4'h4;
	localparam logic [FPG_ADDR_W-1:0] FPG_OFF_MASK = 4'h8;
	localparam logic [FPG_ADDR_W-1:0] FPG_OFF_RESULT = 4'hC;
	// Status / mask bit positions
	localparam int FPG_S_DONE = 0;
	localparam int FPG_S_REFUSED = 1;
	localparam int FPG_NSTAT = 2;
	localparam logic [FPG_NSTAT-1:0] FPG_MASK_RST = 2'h0;
	// Command encodings
	typedef enum logic [2:0] {
		FPG_CMD_READ = 3'h0,
		FPG_CMD_PROG = 3'h1,
		FPG_CMD_BLKERA = 3'h2,
		FPG_CMD_CHPERA = 3'h3,
		FPG_CMD_SETFLG = 3'h4
	} fpg_cmd_type;
	// Answer codes
	localparam logic [1:0] FPG_RSP_OK = 2'h1;
	localparam logic [1:0] FPG_RSP_ERR = 2'h2;
	localparam int FPG_LATENCY = 2;
endpackage : fpg_pkg

/* File: src/fpg_decide.sv */
// Combinational permit decision for one flash command
`timescale 1ns/1ps
`default_nettype none
module fpg_decide
	import fpg_pkg::*;
(
	input wire fpg_pkg::fpg_cmd_type i_cmd,
	input wire logic i_serial,
	input wire logic i_boot_target,
	input wire logic [fpg_pkg::FPG_NFLAG-1:0] i_flags,
	input wire logic [fpg_pkg::FPG_NFLAG-1:0] i_new_flags,
	output logic o_permit
);
	wire logic f_blk = i_flags[FPG_F_BLKERA];
	wire logic f_chp = i_flags[FPG_F_CHPERA];
	wire logic f_prg = i_flags[FPG_F_PROG];
	wire logic f_rd = i_flags[FPG_F_READ];
	wire logic f_boot = i_flags[FPG_F_BOOT];
	wire logic boot_hit = f_boot && i_boot_target;
	// Serial-only prohibits; self-programming ignores them
	wire logic ser_blk_ok = !(f_blk || f_chp || f_prg);
	wire logic ser_chp_ok = !(f_chp || f_boot);
	wire logic ser_prg_ok = !f_prg;
	wire logic ser_rd_ok = !f_rd;
	// Flag update may only add bits; chip erase prohibit freezes serial changes
	wire logic only_adds = ((i_flags & ~i_new_flags) == '0);
	wire logic set_ok = only_adds && !(i_serial && f_chp);
	logic permit;
	always_comb begin
		permit = 1'b0;
		unique case (i_cmd)
			FPG_CMD_READ: permit = i_serial ? ser_rd_ok : 1'b1;
			FPG_CMD_PROG: permit = !boot_hit && (i_serial ? ser_prg_ok : 1'b1);
			FPG_CMD_BLKERA: permit = !boot_hit && (i_serial ? ser_blk_ok : 1'b1);
			FPG_CMD_CHPERA: permit = i_serial && ser_chp_ok;
			FPG_CMD_SETFLG: permit = set_ok;
			default: permit = 1'b0;
		endcase
	end
	assign o_permit = permit;
endmodule : fpg_decide
`default_nettype wire

/* File: src/fpg_gate.sv */
// Flash protection gate: flags, command checking, Avalon-MM registers
//
// Contract
// - Boot flag set: refuse erase and write of boot cluster, both modes.
// - Boot flag, once set, is never cleared. Here i_reset clears it to FPG_FLAGS_RST.
// - After reset all five flags read cleared.
// - Other flags clear only by chip erase. Here i_reset also clears them.
// - Without chip erase, updates only add flags.
// - Block erase prohibit refuses serial block erase only.
// - Program prohibit refuses serial write and serial block erase.
// - Read prohibit refuses serial reads; self reads allowed.
// - Chip erase is never available from self-programming.
// - Boot flag refuses serial chip erase.
// - Four prohibit flags affect serial commands only.
// - Self-programming may set flags, never clear them.
// - Flags live in the extra area; external changes need permission.
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module fpg_gate
	import fpg_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	// Command port
	input wire logic i_cmd_valid,
	input wire fpg_pkg::fpg_cmd_type i_cmd,
	input wire logic i_cmd_serial,
	input wire logic i_cmd_boot,
	input wire logic [fpg_pkg::FPG_NFLAG-1:0] i_cmd_flags,
	output logic o_cmd_ready,
	output logic o_rsp_valid,
	output logic [1:0] o_rsp_code,
	output logic o_exec_valid,
	output fpg_pkg::fpg_cmd_type o_exec_cmd,
	output logic o_exec_boot,
	// Current flags, as held in the extra area
	output logic [fpg_pkg::FPG_NFLAG-1:0] o_flags,
	// Avalon-MM slave
	input wire logic [fpg_pkg::FPG_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [fpg_pkg::FPG_DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [fpg_pkg::FPG_DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	output logic avs_response_err,
	output logic o_irq
);
	import fpg_pkg::*;

	typedef enum logic [2:0] {
		FPG_ST_IDLE = 3'b001,
		FPG_ST_EXEC = 3'b010,
		FPG_ST_RESP = 3'b100
	} fpg_state_type;

	fpg_state_type state_q, state_d;
	logic [FPG_NFLAG-1:0] flags_q, flags_d;
	logic [FPG_NSTAT-1:0] stat_q, stat_d;
	logic [FPG_NSTAT-1:0] mask_q, mask_d;
	fpg_cmd_type cmd_q;
	logic serial_q, boot_q, permit_q;
	logic [FPG_NFLAG-1:0] newf_q;
	logic [1:0] rsp_code_q;
	logic rsp_valid_q, exec_valid_q;
	logic [1:0] last_q;
	logic [FPG_DATA_W-1:0] rdata_q;
	logic ack_q, err_q, irq_q;
	logic wreq_q;

	wire logic permit;
	fpg_decide u_decide (
		.i_cmd(cmd_q),
		.i_serial(serial_q),
		.i_boot_target(boot_q),
		.i_flags(flags_q),
		.i_new_flags(newf_q),
		.o_permit(permit)
	);

	// Command sequencing
	wire logic take_cmd = (state_q == FPG_ST_IDLE) && i_cmd_valid;
	wire logic in_exec = (state_q == FPG_ST_EXEC);
	wire logic done_now = (state_q == FPG_ST_RESP);
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			FPG_ST_IDLE: if (i_cmd_valid) state_d = FPG_ST_EXEC;
			FPG_ST_EXEC: state_d = FPG_ST_RESP;
			FPG_ST_RESP: state_d = FPG_ST_IDLE;
			default: state_d = FPG_ST_IDLE;
		endcase
	end

	// Flag update: chip erase clears all but boot; set-flags only ORs
	wire logic do_chip = in_exec && permit && (cmd_q == FPG_CMD_CHPERA);
	wire logic do_set = in_exec && permit && (cmd_q == FPG_CMD_SETFLG);
	wire logic [FPG_NFLAG-1:0] boot_keep = flags_q & (FPG_NFLAG'(1) << FPG_F_BOOT);
	always_comb begin
		flags_d = flags_q;
		if (do_chip) begin
			flags_d = boot_keep;
		end else if (do_set) begin
			flags_d = flags_q | newf_q;
		end
	end

	// Answer code: refused commands execute nothing
	wire logic [1:0] rsp_d = permit ? FPG_RSP_OK : FPG_RSP_ERR;

	// Register bus decode
	wire logic acc = (avs_read || avs_write) && !ack_q;
	wire logic hit_flags = (avs_address == FPG_OFF_FLAGS);
	wire logic hit_stat = (avs_address == FPG_OFF_STATUS);
	wire logic hit_mask = (avs_address == FPG_OFF_MASK);
	wire logic hit_res = (avs_address == FPG_OFF_RESULT);
	wire logic mapped = hit_flags || hit_stat || hit_mask || hit_res;
	wire logic wr_lo = acc && avs_write && avs_byteenable[0];
	wire logic [FPG_NSTAT-1:0] w1c = (wr_lo && hit_stat) ?
		avs_writedata[FPG_NSTAT-1:0] : '0;
	wire logic [FPG_NSTAT-1:0] events = {
		in_exec && !permit,
		in_exec && permit
	};
	// Set wins over a simultaneous clear
	always_comb begin
		stat_d = (stat_q & ~w1c) | events;
		mask_d = (wr_lo && hit_mask) ? avs_writedata[FPG_NSTAT-1:0] : mask_q;
	end
	wire logic [FPG_DATA_W-1:0] rd_mux =
		hit_flags ? FPG_DATA_W'(flags_q) :
		hit_stat ? FPG_DATA_W'(stat_q) :
		hit_mask ? FPG_DATA_W'(mask_q) :
		hit_res ? FPG_DATA_W'(last_q) : '0;
	wire logic irq_d = |(stat_d & mask_d);

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_q <= FPG_ST_IDLE;
			flags_q <= FPG_FLAGS_RST;
		end else begin
			state_q <= state_d;
			flags_q <= flags_d;
		end
	end

	// Capture of the request while idle
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			cmd_q <= FPG_CMD_READ;
			serial_q <= 1'b0;
			boot_q <= 1'b0;
			newf_q <= '0;
		end else if (take_cmd) begin
			cmd_q <= i_cmd;
			serial_q <= i_cmd_serial;
			boot_q <= i_cmd_boot;
			newf_q <= i_cmd_flags;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			permit_q <= 1'b0;
			rsp_code_q <= 2'h0;
			exec_valid_q <= 1'b0;
			last_q <= 2'h0;
		end else begin
			permit_q <= in_exec ? permit : permit_q;
			rsp_code_q <= in_exec ? rsp_d : rsp_code_q;
			exec_valid_q <= in_exec && permit;
			last_q <= in_exec ? rsp_d : last_q;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rsp_valid_q <= 1'b0;
		end else begin
			rsp_valid_q <= in_exec;
		end
	end

	// One wait cycle: ack rises the cycle after the request
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ack_q <= 1'b0;
			wreq_q <= 1'b1;
			err_q <= 1'b0;
			rdata_q <= '0;
		end else begin
			ack_q <= acc;
			// Own flop so the pin needs no inverter after the register
			wreq_q <= !acc;
			err_q <= acc && !mapped;
			rdata_q <= (acc && avs_read) ? rd_mux : '0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			stat_q <= '0;
			mask_q <= FPG_MASK_RST;
			irq_q <= 1'b0;
		end else begin
			stat_q <= stat_d;
			mask_q <= mask_d;
			irq_q <= irq_d;
		end
	end

	// Idle code is bit 0 of the one-hot state
	assign o_cmd_ready = state_q[0];
	assign o_rsp_valid = rsp_valid_q;
	assign o_rsp_code = rsp_code_q;
	assign o_exec_valid = exec_valid_q;
	assign o_exec_cmd = cmd_q;
	assign o_exec_boot = boot_q;
	assign o_flags = flags_q;
	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wreq_q;
	assign avs_response_err = err_q;
	assign o_irq = irq_q;
endmodule : fpg_gate
`default_nettype wire

/* File: dv/fpg_gate_checker.sv */
// Checker: timing and permit assertions on the gate ports
`timescale 1ns/1ps
`default_nettype none
module fpg_chk
	import fpg_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_cmd_valid,
	input wire fpg_pkg::fpg_cmd_type i_cmd,
	input wire logic i_cmd_serial,
	input wire logic i_cmd_boot,
	input wire logic o_cmd_ready,
	input wire logic o_rsp_valid,
	input wire logic [1:0] o_rsp_code,
	input wire logic o_exec_valid,
	input wire fpg_pkg::fpg_cmd_type o_exec_cmd,
	input wire logic [4:0] o_flags
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	wire tk = i_cmd_valid && o_cmd_ready;
	wire sr = tk && i_cmd_serial;
	wire er = o_rsp_valid && o_rsp_code == FPG_RSP_ERR;
	wire ce = o_exec_valid && o_exec_cmd == FPG_CMD_CHPERA;
	wire bt = tk && i_cmd_boot && o_flags[4] && i_cmd inside {FPG_CMD_PROG, FPG_CMD_BLKERA};
	property p_lat; tk |-> ##2 o_rsp_valid; endproperty
	a_lat: assert property (p_lat) else $error("late answer");
	property p_boot; o_flags[4] |=> o_flags[4]; endproperty
	a_boot: assert property (p_boot) else $error("boot flag lost");
	property p_mono; !ce |-> ($past(o_flags) & ~o_flags) == 5'h00; endproperty
	a_mono: assert property (p_mono) else $error("flag cleared");
	property p_chp;
		tk && i_cmd == FPG_CMD_CHPERA && (!i_cmd_serial || o_flags[1] || o_flags[4])
		|-> ##2 er;
	endproperty
	a_chp: assert property (p_chp) else $error("chip erase passed");
	property p_rd; sr && i_cmd == FPG_CMD_READ && o_flags[3] |-> ##2 er; endproperty
	a_rd: assert property (p_rd) else $error("read passed");
	property p_bt; bt |-> ##2 !o_exec_valid; endproperty
	a_bt: assert property (p_bt) else $error("boot write passed");
	property p_blk; sr && i_cmd == FPG_CMD_BLKERA && o_flags[2:0] != 0 |-> ##2 er; endproperty
	a_blk: assert property (p_blk) else $error("block erase passed");
	property p_ref; er |-> !o_exec_valid && $stable(o_flags); endproperty
	a_ref: assert property (p_ref) else $error("refusal acted");
	c_ce: cover property (ce);
	c_er: cover property (er);
	c_bt: cover property (bt);
endmodule : fpg_chk
bind fpg_gate fpg_chk u_chk(.*);
`default_nettype wire

/* File: dv/fpg_issuer.sv */
// Issuer model: holds each command until the gate takes it
`timescale 1ns/1ps
`default_nettype none
module fpg_issuer
	import fpg_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_go,
	input wire fpg_pkg::fpg_cmd_type i_cmd,
	input wire logic [6:0] i_arg,
	input wire logic i_ready,
	output var logic o_valid = 1'b0,
	output fpg_pkg::fpg_cmd_type o_cmd = FPG_CMD_READ,
	output var logic [6:0] o_arg = 7'h00
);
	// Idle o_arg toggles so stale values are never trusted; o_cmd holds its last value
	always_ff @(posedge i_clk) begin
		if (i_go) begin
			o_valid <= 1'b1;
			o_cmd <= i_cmd;
			o_arg <= i_arg;
		end else if (i_ready || !o_valid) begin
			o_valid <= 1'b0;
			o_arg <= ~o_arg;
		end
	end
endmodule : fpg_issuer
`default_nettype wire

/* File: dv/tb_top.sv */
// Testbench: random commands against a flag model, register checks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import fpg_pkg::*;
	typedef struct packed {
		logic [2:0] m;
		logic b;
		logic p;
		logic [1:0] c;
		logic [4:0] f;
	} fpg_exp_type;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic go = 1'b0;
	logic rd_q = 1'b0;
	logic wr_q = 1'b0;
	logic [3:0] ad = 4'h0;
	logic [31:0] wd = 32'h0;
	logic [6:0] arg = 7'h00;
	logic [4:0] ef;
	logic [1:0] st;
	fpg_cmd_type cmd = FPG_CMD_READ;
	fpg_cmd_type pc, ec;
	wire cv, crdy, rv, ev, eb, wr, err, irq;
	wire [6:0] pa;
	wire [1:0] code;
	wire [4:0] fl;
	wire [31:0] rd;
	int miscompares = 0;
	int n_compared = 0;
	fpg_exp_type q[$];
	logic [32:0] qr[$];
	fpg_issuer u_iss(.i_clk(i_clk), .i_go(go), .i_cmd(cmd), .i_arg(arg), .i_ready(crdy),
		.o_valid(cv), .o_cmd(pc), .o_arg(pa));
	fpg_gate uut(.i_clk(i_clk), .i_reset(i_reset), .i_cmd_valid(cv), .i_cmd(pc),
		.i_cmd_serial(pa[6]), .i_cmd_boot(pa[5]), .i_cmd_flags(pa[4:0]), .o_cmd_ready(crdy),
		.o_rsp_valid(rv), .o_rsp_code(code), .o_exec_valid(ev), .o_exec_cmd(ec),
		.o_exec_boot(eb), .o_flags(fl), .avs_address(ad), .avs_read(rd_q), .avs_write(wr_q),
		.avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rd),
		.avs_waitrequest(wr), .avs_response_err(err), .o_irq(irq));
	initial forever #5 i_clk = ~i_clk;
	task chk(input logic [32:0] s, input logic [32:0] e);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task close_out;
		if (miscompares == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out
	function automatic logic ok(fpg_cmd_type c, logic [6:0] a, logic [4:0] f);
		logic b;
		b = a[5] && f[4];
		case (c)
			FPG_CMD_READ: ok = !(a[6] && f[3]);
			FPG_CMD_PROG: ok = !b && !(a[6] && f[2]);
			FPG_CMD_BLKERA: ok = !b && !(a[6] && f[2:0] != 0);
			FPG_CMD_CHPERA: ok = a[6] && !f[1] && !f[4];
			default: ok = !(a[6] && f[1]) && ((f & ~a[4:0]) == 5'h00);
		endcase
	endfunction : ok
	task issue(input fpg_cmd_type c, input logic [6:0] a);
		logic p;
		int i;
		p = ok(c, a, ef);
		st = st | (p ? 2'h1 : 2'h2);
		if (p && c == FPG_CMD_CHPERA) ef = ef & 5'h10;
		if (p && c == FPG_CMD_SETFLG) ef = ef | a[4:0];
		q.push_back({c, a[5], p, p ? FPG_RSP_OK : FPG_RSP_ERR, ef});
		@(posedge i_clk);
		go <= 1'b1;
		cmd <= c;
		arg <= a;
		@(posedge i_clk);
		go <= 1'b0;
		for (i = 0; i < 20 && q.size() > 0; i++) @(posedge i_clk);
		if (q.size() > 0) begin
			miscompares++;
			close_out();
		end
	endtask : issue
	task av(input logic w, input logic [3:0] a, input logic [31:0] d);
		int i;
		@(posedge i_clk);
		ad <= a;
		rd_q <= !w;
		wr_q <= w;
		wd <= d;
		for (i = 0; i < 20 && wr !== 1'b0; i++) @(posedge i_clk);
		rd_q <= 1'b0;
		wr_q <= 1'b0;
		if (i == 20) begin
			miscompares++;
			close_out();
		end
	endtask : av
	task rdx(input logic [3:0] a, input logic [32:0] e);
		qr.push_back(e);
		av(1'b0, a, 32'h0);
	endtask : rdx
	always @(posedge i_clk) begin
		if (rv === 1'b1) chk({ec, eb, ev, code, fl}, q.pop_front());
		if (rd_q === 1'b1 && wr === 1'b0) chk({err, rd}, qr.pop_front());
	end
	initial begin
		logic [6:0] a;
		int r, k;
		void'($urandom(32'hF7D53FF4));
		for (r = 0; r < 4; r++) begin
			i_reset <= 1'b1;
			repeat (6) @(posedge i_clk);
			i_reset <= 1'b0;
			ef = 5'h00;
			st = 2'h0;
			rdx(FPG_OFF_FLAGS, 33'h0);
			for (k = 0; k < 30; k++) begin
				a = 7'($urandom);
				a[4:0] = 5'h01 << ($urandom % 5);
				repeat ($urandom % 3) @(posedge i_clk);
				issue(fpg_cmd_type'($urandom % 5), a);
			end
			av(1'b1, FPG_OFF_FLAGS, 32'h1F);
			rdx(FPG_OFF_FLAGS, {28'h0, ef});
			rdx(4'h2, {1'b1, 32'h0});
			rdx(FPG_OFF_STATUS, {31'h0, st});
			chk(irq, 1'b0);
			av(1'b1, FPG_OFF_MASK, 32'h3);
			repeat (2) @(posedge i_clk);
			chk(irq, |st);
			av(1'b1, FPG_OFF_STATUS, 32'h3);
			repeat (2) @(posedge i_clk);
			chk(irq, 1'b0);
		end
		close_out();
	end
endmodule : tb_top
`default_nettype wire
